// ===== bme_exec.sv
// Purpose: executes byte loads and stores between general registers and memory
// Assumes: memory port and bus on core_clk_i; mem_ack_i may come any cycle after a request
// Notes:   software loads the instruction, then writes start; busy holds for the state count, or until mem_ack_i if that comes later
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module bme_exec (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          ce_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [bme_pkg::WB_ADR_W-1:0]  wb_adr_i,
  input  wire logic [bme_pkg::DATA_W-1:0]    wb_dat_i,
  input  wire logic [3:0]                    wb_sel_i,
  output logic      [bme_pkg::DATA_W-1:0]    wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               mem_req_o,
  output logic                               mem_we_o,
  output logic      [bme_pkg::DATA_W-1:0]    mem_addr_o,
  output logic      [7:0]                    mem_wdata_o,
  input  wire logic                          mem_ack_i,
  input  wire logic [7:0]                    mem_rdata_i
);
  import bme_pkg::*;

  bme_rf_if rf ();

  bme_regfile #(
    .NUM_REGS (GPR_COUNT)
  ) u_regfile (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .rf         (rf)
  );

  // byte-lane merge for bus writes
  function automatic logic [DATA_W-1:0] wb_merge(input logic [DATA_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] new_v,
                                                 input logic [3:0] sel);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic form_legal(input logic [2:0] f);
    return (f <= BME_LD_PINC);
  endfunction

  function automatic logic form_is_store(input logic [2:0] f);
    return (f == BME_ST_D16) || (f == BME_ST_D24);
  endfunction

  // instruction length in bytes
  function automatic logic [3:0] form_len(input logic [2:0] f);
    case (f)
      BME_LD_D16:  form_len = LEN_D16;
      BME_ST_D16:  form_len = LEN_D16;
      BME_LD_D24:  form_len = LEN_D24;
      BME_ST_D24:  form_len = LEN_D24;
      BME_LD_PINC: form_len = LEN_PINC;
      default:     form_len = 4'h0;
    endcase
  endfunction

  // execution time in states
  function automatic logic [3:0] form_states(input logic [2:0] f);
    case (f)
      BME_LD_D16:  form_states = STATES_D16;
      BME_ST_D16:  form_states = STATES_D16;
      BME_LD_D24:  form_states = STATES_D24;
      BME_ST_D24:  form_states = STATES_D24;
      BME_LD_PINC: form_states = STATES_PINC;
      default:     form_states = 4'h0;
    endcase
  endfunction

  // bus slave state
  logic              ack_r, ack_nxt;
  logic [DATA_W-1:0] dat_r, dat_nxt;

  // core state
  bme_state_t        state_r, state_nxt;
  logic [15:0]       instr_r, instr_nxt;
  logic [23:0]       disp_r, disp_nxt;
  logic [7:0]        flags_r, flags_nxt;
  logic [DATA_W-1:0] pc_r, pc_nxt;
  logic              done_r, done_nxt;
  logic              ill_r, ill_nxt;
  logic [2:0]        form_r, form_nxt;
  logic [BYTE_IDX_W-1:0] bidx_r, bidx_nxt;
  logic [GPR_IDX_W-1:0]  widx_r, widx_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic              req_r, req_nxt;
  logic              we_r, we_nxt;
  logic [DATA_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] base_r, base_nxt;
  logic [7:0]        wdata_r, wdata_nxt;
  logic [7:0]        rbuf_r, rbuf_nxt;

  logic              access;
  logic              bus_wr;
  logic [7:0]        ofs;
  logic              gpr_hit;
  logic [2:0]        cur_form;
  logic [DATA_W-1:0] disp_ext;
  logic [7:0]        moved;
  logic              data_ok;
  logic [DATA_W-1:0] instr_wr;
  logic [DATA_W-1:0] disp_wr;
  logic [DATA_W-1:0] flags_wr;

  // one access per request; ack is dropped the cycle after it was given
  assign access   = wb_cyc_i && wb_stb_i && !ack_r;
  assign bus_wr   = access && wb_we_i;
  assign ofs      = {wb_adr_i[7:2], 2'b00};
  assign gpr_hit  = (ofs[7:5] == OFS_GPR[7:5]);
  assign cur_form = instr_r[INSTR_FORM_LSB +: 3];

  // lane-merged write images of the narrow registers; only their low bits are kept
  assign instr_wr = wb_merge({16'h0000, instr_r}, wb_dat_i, wb_sel_i);
  assign disp_wr  = wb_merge({8'h00, disp_r}, wb_dat_i, wb_sel_i);
  assign flags_wr = wb_merge({24'h00_0000, flags_r}, wb_dat_i, wb_sel_i);

  // register reads are decoded combinationally and registered with the ack
  always_comb begin
    ack_nxt = access;
    dat_nxt = dat_r;
    if (access && !wb_we_i) begin
      dat_nxt = '0;
      if (gpr_hit) begin
        dat_nxt = rf.bus_rdata;
      end else begin
        case (ofs)
          OFS_STATUS: begin
            dat_nxt[STAT_BUSY_BIT] = (state_r == BME_RUN);
            dat_nxt[STAT_DONE_BIT] = done_r;
            dat_nxt[STAT_ILL_BIT]  = ill_r;
          end
          OFS_INSTR: dat_nxt = {16'h0000, instr_r};
          OFS_DISP:  dat_nxt = {8'h00, disp_r};
          OFS_FLAGS: dat_nxt = {24'h00_0000, flags_r};
          OFS_PC:    dat_nxt = pc_r;
          OFS_INFO: begin
            dat_nxt[3:0] = form_len(cur_form);
            dat_nxt[INFO_STATES_LSB +: 4] = form_states(cur_form);
          end
          default:   dat_nxt = '0; // control and unmapped words read as zero
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else if (ce_i) begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // signed displacement of the captured form, widened to 32 bits
  assign disp_ext = (cur_form == BME_LD_D24 || cur_form == BME_ST_D24) ?
                    {{8{disp_r[23]}}, disp_r} : {{16{disp_r[15]}}, disp_r[15:0]};

  // byte carried by the move: the stored source byte or the fetched byte
  assign data_ok = !req_r || mem_ack_i;
  assign moved   = we_r ? wdata_r : ((req_r && mem_ack_i) ? mem_rdata_i : rbuf_r);

  // register file read addresses
  assign rf.byte_ridx = instr_r[INSTR_BYTE_LSB +: BYTE_IDX_W];
  assign rf.wide_ridx = instr_r[INSTR_WIDE_LSB +: GPR_IDX_W];
  assign rf.bus_ridx  = wb_adr_i[4:2];

  // sequencer, program-state registers and register file writes
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    disp_nxt  = disp_r;
    flags_nxt = flags_r;
    pc_nxt    = pc_r;
    done_nxt  = done_r;
    ill_nxt   = ill_r;
    form_nxt  = form_r;
    bidx_nxt  = bidx_r;
    widx_nxt  = widx_r;
    cnt_nxt   = cnt_r;
    req_nxt   = req_r;
    we_nxt    = we_r;
    addr_nxt  = addr_r;
    base_nxt  = base_r;
    wdata_nxt = wdata_r;
    rbuf_nxt  = rbuf_r;
    rf.byte_we    = 1'b0;
    rf.byte_widx  = bidx_r;
    rf.byte_wdata = moved;
    rf.wide_we    = 1'b0;
    rf.wide_widx  = wb_adr_i[4:2];
    rf.wide_wdata = wb_merge(rf.bus_rdata, wb_dat_i, wb_sel_i);

    // sticky flags clear on a written one; a same-cycle event still sets them
    if (bus_wr && ofs == OFS_STATUS && wb_sel_i[0]) begin
      if (wb_dat_i[STAT_DONE_BIT]) begin
        done_nxt = 1'b0;
      end
      if (wb_dat_i[STAT_ILL_BIT]) begin
        ill_nxt = 1'b0;
      end
    end
    if (bus_wr && ofs == OFS_INSTR) begin
      instr_nxt = instr_wr[15:0];
    end
    if (bus_wr && ofs == OFS_DISP) begin
      disp_nxt = disp_wr[23:0];
    end

    case (state_r)
      BME_IDLE: begin
        // architectural state is only writable while nothing executes
        if (bus_wr && ofs == OFS_FLAGS) begin
          flags_nxt = flags_wr[7:0];
        end
        if (bus_wr && ofs == OFS_PC) begin
          pc_nxt = wb_merge(pc_r, wb_dat_i, wb_sel_i);
        end
        if (bus_wr && gpr_hit) begin
          rf.wide_we = 1'b1;
        end
        if (bus_wr && ofs == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT]) begin
          if (form_legal(cur_form)) begin
            state_nxt = BME_RUN;
            form_nxt  = cur_form;
            bidx_nxt  = rf.byte_ridx;
            widx_nxt  = rf.wide_ridx;
            cnt_nxt   = form_states(cur_form);
            base_nxt  = rf.wide_rdata;
            req_nxt   = 1'b1;
            we_nxt    = form_is_store(cur_form);
            wdata_nxt = rf.byte_rdata;
            addr_nxt  = (cur_form == BME_LD_PINC) ? rf.wide_rdata
                                                  : rf.wide_rdata + disp_ext;
          end else begin
            ill_nxt = 1'b1;
          end
        end
      end
      BME_RUN: begin
        if (req_r && mem_ack_i) begin
          req_nxt  = 1'b0;
          rbuf_nxt = mem_rdata_i;
        end
        if (cnt_r > 4'h1) begin
          cnt_nxt = cnt_r - 4'h1;
        end
        // retire once the state count has run out and memory has answered
        if (cnt_r <= 4'h1 && data_ok) begin
          state_nxt = BME_IDLE;
          req_nxt   = 1'b0;
          cnt_nxt   = 4'h0;
          done_nxt  = 1'b1;
          pc_nxt    = pc_r + {28'h000_0000, form_len(form_r)};
          flags_nxt[FLAG_N_BIT] = moved[7];
          flags_nxt[FLAG_Z_BIT] = (moved == 8'h00);
          flags_nxt[FLAG_V_BIT] = 1'b0;
          flags_nxt[FLAG_C_BIT] = flags_r[FLAG_C_BIT];
          if (!we_r) begin
            rf.byte_we = 1'b1;
          end
          if (form_r == BME_LD_PINC) begin
            rf.wide_we    = 1'b1;
            rf.wide_widx  = widx_r;
            rf.wide_wdata = base_r + 32'h0000_0001;
          end
        end
      end
      default: state_nxt = BME_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= BME_IDLE;
      instr_r <= INSTR_RST;
      disp_r  <= DISP_RST;
      flags_r <= FLAGS_RST;
      pc_r    <= PC_RST;
      done_r  <= 1'b0;
      ill_r   <= 1'b0;
      form_r  <= 3'b000;
      bidx_r  <= '0;
      widx_r  <= '0;
      cnt_r   <= 4'h0;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= '0;
      base_r  <= '0;
      wdata_r <= 8'h00;
      rbuf_r  <= 8'h00;
    end else if (ce_i) begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      disp_r  <= disp_nxt;
      flags_r <= flags_nxt;
      pc_r    <= pc_nxt;
      done_r  <= done_nxt;
      ill_r   <= ill_nxt;
      form_r  <= form_nxt;
      bidx_r  <= bidx_nxt;
      widx_r  <= widx_nxt;
      cnt_r   <= cnt_nxt;
      req_r   <= req_nxt;
      we_r    <= we_nxt;
      addr_r  <= addr_nxt;
      base_r  <= base_nxt;
      wdata_r <= wdata_nxt;
      rbuf_r  <= rbuf_nxt;
    end
  end

  // memory port straight from flops; held stable until mem_ack_i
  assign mem_req_o   = req_r;
  assign mem_we_o    = we_r;
  assign mem_addr_o  = addr_r;
  assign mem_wdata_o = wdata_r;
endmodule
`default_nettype wire

// ===== bme_pkg.sv
// Purpose: shared constants, types and helpers of the byte move execution unit
// Assumes: classic Wishbone slave with 32-bit data and byte-addressed word registers
// Notes:   byte register codes 0..7 pick the upper byte halves, 8..15 the lower ones
package bme_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned WB_ADR_W  = 8;
  localparam int unsigned GPR_COUNT = 8;
  localparam int unsigned GPR_IDX_W = 3;
  localparam int unsigned BYTE_IDX_W = 4;

  // register offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INSTR  = 8'h08;
  localparam logic [7:0] OFS_DISP   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_PC     = 8'h14;
  localparam logic [7:0] OFS_INFO   = 8'h18;
  localparam logic [7:0] OFS_GPR    = 8'h40;

  // field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;
  localparam int unsigned STAT_ILL_BIT   = 2;
  localparam int unsigned FLAG_C_BIT     = 0;
  localparam int unsigned FLAG_V_BIT     = 1;
  localparam int unsigned FLAG_Z_BIT     = 2;
  localparam int unsigned FLAG_N_BIT     = 3;
  localparam int unsigned INSTR_FORM_LSB = 0;
  localparam int unsigned INSTR_WIDE_LSB = 4;
  localparam int unsigned INSTR_BYTE_LSB = 8;
  localparam int unsigned INFO_STATES_LSB = 8;

  // reset values
  localparam logic [7:0]        FLAGS_RST = 8'h00;
  localparam logic [DATA_W-1:0] PC_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] GPR_RST   = 32'h0000_0000;
  localparam logic [15:0]       INSTR_RST = 16'h0000;
  localparam logic [23:0]       DISP_RST  = 24'h00_0000;

  // instruction lengths in bytes and execution counts in states (cycles)
  localparam logic [3:0] LEN_D16    = 4'h4;
  localparam logic [3:0] LEN_D24    = 4'h8;
  localparam logic [3:0] LEN_PINC   = 4'h2;
  localparam logic [3:0] STATES_D16 = 4'h6;
  localparam logic [3:0] STATES_D24 = 4'hA;
  localparam logic [3:0] STATES_PINC = 4'h6;

  typedef enum logic [2:0] {
    BME_LD_D16  = 3'b000,
    BME_LD_D24  = 3'b001,
    BME_ST_D16  = 3'b010,
    BME_ST_D24  = 3'b011,
    BME_LD_PINC = 3'b100
  } bme_form_t;

  typedef enum logic [0:0] {
    BME_IDLE = 1'b0,
    BME_RUN  = 1'b1
  } bme_state_t;

  // code bit 3 set selects the low byte of the register, clear the upper byte
  function automatic logic [7:0] bme_byte_of(input logic [DATA_W-1:0] word,
                                             input logic [BYTE_IDX_W-1:0] idx);
    return idx[3] ? word[7:0] : word[15:8];
  endfunction

  function automatic logic [DATA_W-1:0] bme_byte_put(input logic [DATA_W-1:0] word,
                                                     input logic [BYTE_IDX_W-1:0] idx,
                                                     input logic [7:0] b);
    return idx[3] ? {word[31:8], b} : {word[31:16], b, word[7:0]};
  endfunction

endpackage

// ===== bme_rf_if.sv
// Purpose: port bundle between the executor and its register file
// Assumes: one clock; reads are combinational, writes land at the next edge
// Notes:   the executor owns every write; the file only stores and serves
`timescale 1ns/10ps
`default_nettype none
interface bme_rf_if;
  import bme_pkg::*;
  logic [BYTE_IDX_W-1:0] byte_ridx;
  logic [7:0]            byte_rdata;
  logic [GPR_IDX_W-1:0]  wide_ridx;
  logic [DATA_W-1:0]     wide_rdata;
  logic [GPR_IDX_W-1:0]  bus_ridx;
  logic [DATA_W-1:0]     bus_rdata;
  logic                  byte_we;
  logic [BYTE_IDX_W-1:0] byte_widx;
  logic [7:0]            byte_wdata;
  logic                  wide_we;
  logic [GPR_IDX_W-1:0]  wide_widx;
  logic [DATA_W-1:0]     wide_wdata;

  modport exec (output byte_ridx, wide_ridx, bus_ridx, byte_we, byte_widx, byte_wdata,
                output wide_we, wide_widx, wide_wdata,
                input  byte_rdata, wide_rdata, bus_rdata);
  modport regfile (input byte_ridx, wide_ridx, bus_ridx, byte_we, byte_widx, byte_wdata,
                   input  wide_we, wide_widx, wide_wdata,
                   output byte_rdata, wide_rdata, bus_rdata);
endinterface
`default_nettype wire

// ===== bme_regfile.sv
// Purpose: eight 32-bit general registers with byte and word views
// Assumes: a byte write and a wide write may land in one cycle, on one register or on two
// Notes:   when both hit one register the byte write is applied last and wins
`timescale 1ns/10ps
`default_nettype none
module bme_regfile #(
  parameter int unsigned NUM_REGS = 8
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  bme_rf_if.regfile rf
);
  import bme_pkg::*;

  logic [DATA_W-1:0] gpr_r   [NUM_REGS];
  logic [DATA_W-1:0] gpr_nxt [NUM_REGS];

  // each wide register holds an extended half (31:16) and a low half (15:0);
  // the low half is split again into an upper and a lower byte register
  assign rf.byte_rdata = bme_byte_of(gpr_r[rf.byte_ridx[2:0]], rf.byte_ridx);
  assign rf.wide_rdata = gpr_r[rf.wide_ridx];
  assign rf.bus_rdata  = gpr_r[rf.bus_ridx];

  // next value: wide write first, then the byte write on top of it
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      gpr_nxt[i] = gpr_r[i];
    end
    if (rf.wide_we) begin
      gpr_nxt[rf.wide_widx] = rf.wide_wdata;
    end
    if (rf.byte_we) begin
      gpr_nxt[rf.byte_widx[2:0]] = bme_byte_put(gpr_nxt[rf.byte_widx[2:0]],
                                                rf.byte_widx, rf.byte_wdata);
    end
  end

  // storage
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        gpr_r[i] <= GPR_RST;
      end
    end else if (ce_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        gpr_r[i] <= gpr_nxt[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== bme_exec_sva.sv
// Purpose: port-level checks of the byte move executor
// Assumes: sees only the top ports; the form field is followed from bus writes
// Notes:   writes to the instruction register while busy are not modelled here
`timescale 1ns/10ps
`default_nettype none
module bme_exec_sva
  import bme_pkg::*;
(
  input wire logic                core_clk_i,
  input wire logic                rst_n_i,
  input wire logic                ce_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0]   wb_dat_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [DATA_W-1:0]   wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                mem_req_o,
  input wire logic                mem_we_o,
  input wire logic [DATA_W-1:0]   mem_addr_o,
  input wire logic [7:0]          mem_wdata_o,
  input wire logic                mem_ack_i,
  input wire logic [7:0]          mem_rdata_i
);
  logic [2:0] form_r;
  logic [2:0] form_nxt;
  logic       take;

  // an accepted bus cycle; a low clock enable freezes the slave
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;

  // follow the form field so that a new memory request can be judged
  always_comb begin
    form_nxt = form_r;
    if (take && wb_we_i && wb_adr_i[7:2] == OFS_INSTR[7:2] && wb_sel_i[0]) begin
      form_nxt = wb_dat_i[2:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      form_r <= 3'h0;
    end else begin
      form_r <= form_nxt;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ack_one_pulse: assert property ((wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("bus ack missing one cycle after request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i && ce_i))
    else $error("bus ack without a request");
  a_req_holds: assert property ((mem_req_o && !(mem_ack_i && ce_i)) |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("memory request changed before its answer");
  a_req_releases: assert property ((mem_req_o && mem_ack_i && ce_i) |=> !mem_req_o)
    else $error("memory request kept after answer");
  a_req_from_start: assert property ($rose(mem_req_o) |->
    $past(take && wb_we_i && wb_adr_i[7:2] == OFS_CTRL[7:2] && wb_dat_i[0] && form_r < 3'h5))
    else $error("memory request without a legal start");
  a_dir_by_form: assert property ($rose(mem_req_o) |->
    mem_we_o == (form_r == 3'h2 || form_r == 3'h3))
    else $error("memory direction does not match form");
  a_ce_freezes: assert property (!ce_i |=>
    $stable(wb_ack_o) && $stable(mem_req_o) && $stable(mem_addr_o))
    else $error("outputs moved while clock enable low");

  // main scenarios reached
  c_store: cover property ($rose(mem_req_o) && mem_we_o);
  c_load_ack: cover property (mem_req_o && mem_ack_i && !mem_we_o);
  c_stall: cover property (!ce_i && mem_req_o);
endmodule

bind bme_exec bme_exec_sva bme_exec_sva_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
  .mem_rdata_i(mem_rdata_i));
`default_nettype wire

// ===== bme_exec_test.sv
// Purpose: self-checking bench of the byte move executor
// Assumes: bus answers one cycle after take; memory answers within three cycles
// Notes:   status is read at the exact edge where busy must still hold or be gone
`timescale 1ns/10ps
`default_nettype none
module bme_exec_test;
  import bme_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mem_req_o;
  logic        mem_we_o;
  logic [31:0] mem_addr_o;
  logic [7:0]  mem_wdata_o;
  logic        mem_ack_i = 1'b0;
  logic [7:0]  mem_rdata_i = 8'h00;
  logic [31:0] seen_addr;
  logic        seen_we;
  logic [7:0]  seen_wd;
  logic [7:0]  rd_byte;
  logic [7:0]  rst_ofs [6] = '{OFS_FLAGS, OFS_PC, OFS_INSTR, OFS_DISP, OFS_STATUS, OFS_GPR};
  int          mismatches = 0;
  int          n_tests = 0;
  int          lat = 0;
  int          wait_cnt = 0;
  int          n_req = 0;

  bme_exec bme_exec_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));

  always #2.5 core_clk_i = ~core_clk_i;

  // memory answers after lat cycles; idle data toggles so stale bytes never match
  always @(posedge core_clk_i) begin
    if (mem_req_o && !mem_ack_i && wait_cnt >= lat) begin
      mem_ack_i <= 1'b1;
      mem_rdata_i <= rd_byte;
      seen_addr <= mem_addr_o;
      seen_we <= mem_we_o;
      seen_wd <= mem_wdata_o;
      n_req <= n_req + 1;
      wait_cnt <= 0;
    end else begin
      mem_ack_i <= 1'b0;
      mem_rdata_i <= ~mem_rdata_i;
      wait_cnt <= (mem_req_o && !mem_ack_i) ? wait_cnt + 1 : 0;
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; held until ack is sampled, then released for a cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int k;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      tally_and_finish();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic run(input logic [2:0] f, input logic [2:0] wr, input logic [3:0] bc,
                     input logic [23:0] disp, input int extra, input int stall);
    logic [31:0] q, base, src, pc0, ea, ex;
    logic [7:0]  fl0, b, mv;
    logic        st_f;
    int          ns, ln;
    st_f = f[1] && !f[2];
    ns = f[0] ? 10 : 6;
    ln = f[2] ? 2 : (f[0] ? 8 : 4);
    lat = stall ? 0 : $urandom_range(2);
    rd_byte = $urandom_range(3) ? 8'($urandom) : 8'h00;
    fl0 = 8'($urandom);
    xfer(0, OFS_GPR + {wr, 2'b00}, 0, base);
    xfer(0, OFS_GPR + {bc[2:0], 2'b00}, 0, src);
    xfer(0, OFS_PC, 0, pc0);
    xfer(1, OFS_FLAGS, {24'h0, fl0}, q);
    xfer(1, OFS_STATUS, 32'h6, q);
    xfer(1, OFS_INSTR, {20'h0, bc, 1'b0, wr, 1'b0, f}, q);
    xfer(1, OFS_DISP, {8'h0, disp}, q);
    xfer(0, OFS_INFO, 0, q);
    check("info", {20'h0, 4'(ns), 4'h0, 4'(ln)}, q);
    xfer(1, OFS_CTRL, 32'h1, q);
    // clock enable low stretches the run by the stalled edges
    if (stall > 0) begin
      ce_i <= 1'b0;
      repeat (stall) @(posedge core_clk_i);
      ce_i <= 1'b1;
    end
    repeat (ns + extra - 3) @(posedge core_clk_i);
    xfer(0, OFS_STATUS, 0, q);
    check("status", extra ? 32'h2 : 32'h1, q);
    repeat (4) @(posedge core_clk_i);
    ea = f[2] ? base : base + (f[0] ? {{8{disp[23]}}, disp} : {{16{disp[15]}}, disp[15:0]});
    check("addr", ea, seen_addr);
    check("dir", {31'h0, st_f}, {31'h0, seen_we});
    b = bc[3] ? src[7:0] : src[15:8];
    mv = st_f ? b : rd_byte;
    if (st_f) begin
      check("wdata", {24'h0, b}, {24'h0, seen_wd});
    end else begin
      ex = (f[2] && bc[2:0] == wr) ? base + 32'h1 : src;
      ex = bc[3] ? {ex[31:8], mv} : {ex[31:16], mv, ex[7:0]};
      xfer(0, OFS_GPR + {bc[2:0], 2'b00}, 0, q);
      check("dest", ex, q);
      if (f[2] && bc[2:0] != wr) begin
        xfer(0, OFS_GPR + {wr, 2'b00}, 0, q);
        check("incr", base + 32'h1, q);
      end
    end
    xfer(0, OFS_FLAGS, 0, q);
    check("flags", {24'h0, fl0[7:4], mv[7], mv == 8'h00, 1'b0, fl0[0]}, q);
    xfer(0, OFS_PC, 0, q);
    check("pc", pc0 + ln, q);
  endtask

  initial begin
    logic [31:0] q;
    int          k;
    void'($urandom(88696));
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    foreach (rst_ofs[j]) begin
      xfer(0, rst_ofs[j], 0, q);
      check("reset", 32'h0, q);
    end
    // every form and every byte code, zero bytes and sign-bit displacements among them
    for (int i = 0; i < 40; i++) begin
      for (int j = 0; j < 8; j++) begin
        xfer(1, OFS_GPR + 8'(4 * j), (i % 4 == 1) ? 32'h0 : $urandom, q);
      end
      run(3'(i % 5), 3'($urandom_range(7)), (i < 16) ? 4'(i) : 4'($urandom_range(15)),
          (i % 3 == 0) ? 24'h80_8000 : 24'($urandom), i % 2, (i == 7) ? 2 : 0);
    end
    // unknown forms raise the illegal flag and never touch memory
    for (int f = 5; f < 8; f++) begin
      k = n_req;
      xfer(1, OFS_INSTR, 32'(f), q);
      xfer(0, OFS_INFO, 0, q);
      check("info_ill", 32'h0, q);
      xfer(1, OFS_CTRL, 32'h1, q);
      repeat (8) @(posedge core_clk_i);
      xfer(0, OFS_STATUS, 0, q);
      check("ill", 32'h4, q & 32'h5);
      check("noreq", 32'(k), 32'(n_req));
      xfer(1, OFS_STATUS, 32'h6, q);
    end
    xfer(1, 8'h30, 32'hFFFF_FFFF, q);
    xfer(0, 8'h30, 0, q);
    check("unmapped", 32'h0, q);
    // partial byte lanes: only the two low bytes of the word take the write
    xfer(1, OFS_GPR, 32'h1234_5678, q);
    wb_sel_i <= 4'h3;
    xfer(1, OFS_GPR, 32'hFFFF_FFFF, q);
    wb_sel_i <= 4'hF;
    xfer(0, OFS_GPR, 0, q);
    check("lanes", 32'h1234_FFFF, q);
    tally_and_finish();
  end
endmodule
`default_nettype wire
